// File: design/nvmsf_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Interrupt control bits 3:2 enable self-program ready request and set its level.
// - Interrupt control bits 1:0 enable memory-ready request and set its level.
// - An enabled ready request stays asserted while the busy flag reads zero.
// - Status bit 7 sets when any programming starts, clears when it completes.
// - Status bit 6 sets during flash erase or write; application section is blocked.
// - Status bits 5:2 always read zero.
// - Status bit 1 sets on first EEPROM buffer byte, clears on write or flush.
// - Status bit 0 sets on flash buffer load, clears on page write or flush.
// - Lock bits are readable as a mirror of their stored value.
// - Fuse byte 0 is copied to the test port user identity at reset.
// - Fuse byte 1 bits 7:4 preset the watchdog window period.
// - Fuse byte 1 bits 3:0 preset the watchdog timeout period.
// - Fuse byte 2 bit 6 picks boot loader start (0) or address zero (1).
// - Fuse byte 2 bits 1:0 give brown-out mode in deep sleep.
// - Programmed fuse byte 4 bit 4 ignores the external reset pin.
// - Fuse byte 4 bits 3:2 select a 64, 4 or 0 cycle start-up delay.
// - Fuse byte 4 bit 1 zero locks watchdog and forces its enable at reset.
// - Fuse byte 4 bit 0 zero enables the test port, one refuses it.
// - Command execute starts the held command, only inside the protection window.
module nvmsf_top #(
	parameter int BUSY_CYCLES = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_ccp_key_wr,
	input wire logic i_ulp_tick,
	input wire logic i_ext_reset_n,
	output logic [7:0] o_rdata,
	output logic [1:0] o_selfprog_irq_level,
	output logic [1:0] o_eeprom_irq_level,
	output logic o_flash_section_busy,
	output logic o_ext_reset,
	output logic o_internal_reset,
	output nvmsf_pkg::nvmsf_cfg_t o_cfg
);

	initial begin
		if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin
			$error("BUSY_CYCLES out of range");
		end
	end

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	nvmsf_pkg::nvmsf_bus_t bus;
	nvmsf_pkg::nvmsf_state_t state;
	logic [7:0] fuse0;
	logic [7:0] fuse1;
	logic [7:0] fuse2;
	logic [7:0] fuse4;
	logic [7:0] lock_bits;
	logic [7:0] nvm_interrupt_control;
	logic [6:0] cmd;
	logic busy;
	logic flash_section_busy_flag;
	logic ee_loaded;
	logic fl_loaded;
	logic [7:0] busy_cnt;
	logic [6:0] cmd_run;
	logic [2:0] ccp_cnt;
	logic [6:0] sut_cnt;
	logic [7:0] next_rdata;

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire wr_fuse0 = bus.wr && bus.addr == nvmsf_pkg::ADDR_FUSE0;
	wire wr_fuse1 = bus.wr && bus.addr == nvmsf_pkg::ADDR_FUSE1;
	wire wr_fuse2 = bus.wr && bus.addr == nvmsf_pkg::ADDR_FUSE2;
	wire wr_fuse4 = bus.wr && bus.addr == nvmsf_pkg::ADDR_FUSE4;
	wire wr_nvm_interrupt_control = bus.wr && bus.addr == nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL;
	wire wr_cmd = bus.wr && bus.addr == nvmsf_pkg::ADDR_CMD;
	wire wr_exec = bus.wr && bus.addr == nvmsf_pkg::ADDR_EXEC;
	wire wr_data = bus.wr && bus.addr == nvmsf_pkg::ADDR_DATA;
	wire wr_mapload = bus.wr && bus.addr == nvmsf_pkg::ADDR_MAPLOAD;
	wire ccp_open = ccp_cnt != 3'h0;

	wire exec_go = wr_exec && bus.wdata[0] && ccp_open && !busy && state == nvmsf_pkg::ST_RUN;

	// Command kinds
	wire is_ee_write = cmd == nvmsf_pkg::CMD_EE_WRITE;
	wire is_app_write = cmd == nvmsf_pkg::CMD_APP_WRITE;
	wire is_boot_write = cmd == nvmsf_pkg::CMD_BOOT_WRITE;
	wire is_app_erase = cmd == nvmsf_pkg::CMD_APP_ERASE;
	wire is_lock_write = cmd == nvmsf_pkg::CMD_LOCK_WRITE;
	wire is_prog = is_ee_write || is_app_write || is_boot_write || is_app_erase || is_lock_write;
	wire is_flash_op = is_app_write || is_boot_write || is_app_erase;
	wire start_prog = exec_go && is_prog;
	wire done = busy && busy_cnt == 8'h01;

	// buffer load set and clear terms
	wire ee_load_set = (wr_data && cmd == nvmsf_pkg::CMD_EE_LOAD) || wr_mapload;
	wire ee_load_clr = (exec_go && is_ee_write) || (exec_go && cmd == nvmsf_pkg::CMD_EE_FLUSH);
	// flash buffer set and clear terms
	wire fl_load_set = wr_data && cmd == nvmsf_pkg::CMD_FL_LOAD;
	wire fl_load_clr = (exec_go && (is_app_write || is_boot_write)) || (exec_go && cmd == nvmsf_pkg::CMD_FL_FLUSH);

	// ----------------------------------------
	// Start-up delay
	// ----------------------------------------
	logic [6:0] sut_load;
	assign sut_load = fuse4[nvmsf_pkg::F4_SUT_HI:nvmsf_pkg::F4_SUT_LO] == nvmsf_pkg::SUT_64 ? nvmsf_pkg::SUT_CNT_64 :
		fuse4[nvmsf_pkg::F4_SUT_HI:nvmsf_pkg::F4_SUT_LO] == nvmsf_pkg::SUT_4 ? nvmsf_pkg::SUT_CNT_4 :
		nvmsf_pkg::SUT_CNT_0;

	// Sequence fuse copy, delay, then run
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= nvmsf_pkg::ST_LOAD;
			sut_cnt <= 7'h00;
		end else begin
			case (state)
				nvmsf_pkg::ST_LOAD: begin
					state <= nvmsf_pkg::ST_WAIT;
					sut_cnt <= sut_load;
				end
				nvmsf_pkg::ST_WAIT: begin
					if (sut_cnt == 7'h00) begin
						state <= nvmsf_pkg::ST_RUN;
					end else if (i_ulp_tick) begin
						sut_cnt <= sut_cnt - 7'h01;
					end
				end
				nvmsf_pkg::ST_RUN: begin
					state <= nvmsf_pkg::ST_RUN;
				end
				default: begin
					state <= nvmsf_pkg::ST_LOAD;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Fuse and lock storage
	// ----------------------------------------
	// erased fuses read one
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fuse0 <= nvmsf_pkg::RST_FUSE0;
			fuse1 <= nvmsf_pkg::RST_FUSE1;
			fuse2 <= nvmsf_pkg::RST_FUSE2;
			fuse4 <= nvmsf_pkg::RST_FUSE4;
			lock_bits <= nvmsf_pkg::RST_LOCK;
		end else begin
			if (wr_fuse0) fuse0 <= bus.wdata;
			if (wr_fuse1) fuse1 <= bus.wdata;
			if (wr_fuse2) fuse2 <= bus.wdata;
			if (wr_fuse4) fuse4 <= bus.wdata;
			if (done && cmd_run == nvmsf_pkg::CMD_LOCK_WRITE) lock_bits <= lock_bits & bus.wdata;
		end
	end

	// Copies into other units, taken only while loading
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cfg <= '1;
		end else if (state == nvmsf_pkg::ST_LOAD) begin
			o_cfg.user_ident <= fuse0;
			o_cfg.window_period <= fuse1[nvmsf_pkg::F1_WIN_HI:nvmsf_pkg::F1_WIN_LO];
			o_cfg.timeout_period <= fuse1[nvmsf_pkg::F1_TMO_HI:nvmsf_pkg::F1_TMO_LO];
			o_cfg.boot_vector_app <= fuse2[nvmsf_pkg::F2_BOOT];
			o_cfg.brownout_sleep_mode <= fuse2[nvmsf_pkg::F2_BOD_HI:nvmsf_pkg::F2_BOD_LO];
			o_cfg.ext_reset_pin_disable <= !fuse4[nvmsf_pkg::F4_RSTDIS];
			o_cfg.watchdog_config_lock <= !fuse4[nvmsf_pkg::F4_WATCHDOG_CONFIG_LOCK];
			o_cfg.watchdog_auto_enable <= !fuse4[nvmsf_pkg::F4_WATCHDOG_CONFIG_LOCK];
			o_cfg.test_port_enable <= !fuse4[nvmsf_pkg::F4_TPEN];
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// level fields stored
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nvm_interrupt_control <= nvmsf_pkg::RST_ZERO;
			cmd <= nvmsf_pkg::CMD_NOP;
			ccp_cnt <= 3'h0;
		end else begin
			if (wr_nvm_interrupt_control) nvm_interrupt_control <= bus.wdata & nvmsf_pkg::NVM_INTERRUPT_CONTROL_MASK;
			if (wr_cmd) cmd <= bus.wdata[6:0];
			if (i_ccp_key_wr) ccp_cnt <= nvmsf_pkg::CCP_WINDOW;
			else if (ccp_open) ccp_cnt <= ccp_cnt - 3'h1;
		end
	end

	// ----------------------------------------
	// Busy tracking
	// ----------------------------------------
	// busy set and clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy <= 1'b0;
			flash_section_busy_flag <= 1'b0;
			busy_cnt <= 8'h00;
			cmd_run <= nvmsf_pkg::CMD_NOP;
		end else if (start_prog) begin
			busy <= 1'b1;
			flash_section_busy_flag <= is_flash_op;
			busy_cnt <= 8'(BUSY_CYCLES);
			cmd_run <= cmd;
		end else if (busy) begin
			busy_cnt <= busy_cnt - 8'h01;
			if (done) begin
				busy <= 1'b0;
				flash_section_busy_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ee_loaded <= 1'b0;
			fl_loaded <= 1'b0;
		end else begin
			if (ee_load_set) ee_loaded <= 1'b1;
			else if (ee_load_clr) ee_loaded <= 1'b0;
			if (fl_load_set) fl_loaded <= 1'b1;
			else if (fl_load_clr) fl_loaded <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] status;
	assign status = {busy, flash_section_busy_flag, 4'h0, ee_loaded, fl_loaded};
	assign next_rdata = !bus.rd ? 8'h00 :
		bus.addr == nvmsf_pkg::ADDR_FUSE0 ? fuse0 :
		bus.addr == nvmsf_pkg::ADDR_FUSE1 ? fuse1 :
		bus.addr == nvmsf_pkg::ADDR_FUSE2 ? fuse2 :
		bus.addr == nvmsf_pkg::ADDR_FUSE4 ? fuse4 :
		bus.addr == nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL ? nvm_interrupt_control :
		bus.addr == nvmsf_pkg::ADDR_STATUS ? status :
		bus.addr == nvmsf_pkg::ADDR_LOCK ? lock_bits :
		bus.addr == nvmsf_pkg::ADDR_CMD ? {1'b0, cmd} : 8'h00;

	// Read data one cycle later
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Requests and resets
	// ----------------------------------------
	// level requests while idle
	assign o_selfprog_irq_level = busy ? 2'h0 : nvm_interrupt_control[nvmsf_pkg::SPM_LVL_HI:nvmsf_pkg::SPM_LVL_LO];
	assign o_eeprom_irq_level = busy ? 2'h0 : nvm_interrupt_control[nvmsf_pkg::EE_LVL_HI:nvmsf_pkg::EE_LVL_LO];
	assign o_flash_section_busy = flash_section_busy_flag;
	assign o_ext_reset = !i_ext_reset_n && !o_cfg.ext_reset_pin_disable;
	// internal reset held until copies and start-up delay done
	assign o_internal_reset = state != nvmsf_pkg::ST_RUN;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	irq_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		busy |-> o_eeprom_irq_level == 2'h0 && o_selfprog_irq_level == 2'h0)
		else $error("ready request while busy");
	irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!busy |-> o_selfprog_irq_level == nvm_interrupt_control[3:2])
		else $error("self-program level wrong");
	ee_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!busy |-> o_eeprom_irq_level == nvm_interrupt_control[1:0])
		else $error("eeprom level wrong");
	busy_start_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		start_prog |=> busy [*1] ##(BUSY_CYCLES) !busy)
		else $error("busy length wrong");
	flash_section_busy_flag_sub_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		flash_section_busy_flag |-> busy)
		else $error("flash busy without busy");
	status_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$past(bus.rd && bus.addr == nvmsf_pkg::ADDR_STATUS) |-> o_rdata[5:2] == 4'h0)
		else $error("reserved status nonzero");
	ee_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		ee_load_set |=> ee_loaded)
		else $error("eeprom load flag missed");
	fl_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		fl_load_clr && !fl_load_set |=> !fl_loaded)
		else $error("flash load flag stuck");
	lock_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		bus.rd && bus.addr == nvmsf_pkg::ADDR_LOCK |=> o_rdata == $past(lock_bits))
		else $error("lock mirror wrong");
	exec_guard_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		start_prog |-> ccp_cnt != 3'h0)
		else $error("execute outside protection window");
	copy_before_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state == nvmsf_pkg::ST_LOAD |=> o_cfg.user_ident == $past(fuse0) && o_internal_reset)
		else $error("fuse copy late");

endmodule

// File: design/nvmsf_pkg.sv
package nvmsf_pkg;

	// ----------------------------------------
	// Register indices (byte address = index)
	// ----------------------------------------
	localparam logic [7:0] ADDR_FUSE0 = 8'h00;
	localparam logic [7:0] ADDR_FUSE1 = 8'h01;
	localparam logic [7:0] ADDR_FUSE2 = 8'h02;
	localparam logic [7:0] ADDR_FUSE4 = 8'h04;
	localparam logic [7:0] ADDR_NVM_INTERRUPT_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h11;
	localparam logic [7:0] ADDR_LOCK = 8'h12;
	localparam logic [7:0] ADDR_CMD = 8'h13;
	localparam logic [7:0] ADDR_EXEC = 8'h14;
	localparam logic [7:0] ADDR_DATA = 8'h15;
	localparam logic [7:0] ADDR_MAPLOAD = 8'h16;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FUSE0 = 8'hff;
	localparam logic [7:0] RST_FUSE1 = 8'hff;
	localparam logic [7:0] RST_FUSE2 = 8'hff;
	localparam logic [7:0] RST_FUSE4 = 8'hfe;
	localparam logic [7:0] RST_LOCK = 8'hff;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SPM_LVL_HI = 3;
	localparam int SPM_LVL_LO = 2;
	localparam int EE_LVL_HI = 1;
	localparam int EE_LVL_LO = 0;
	localparam int ST_BUSY = 7;
	localparam int ST_FLASH_SECTION_BUSY_FLAG = 6;
	localparam int ST_EEPROM_BUFFER_LOADED_FLAG = 1;
	localparam int ST_FLASH_BUFFER_LOADED_FLAG = 0;
	localparam int F1_WIN_HI = 7;
	localparam int F1_WIN_LO = 4;
	localparam int F1_TMO_HI = 3;
	localparam int F1_TMO_LO = 0;
	localparam int F2_BOOT = 6;
	localparam int F2_BOD_HI = 1;
	localparam int F2_BOD_LO = 0;
	localparam int F4_RSTDIS = 4;
	localparam int F4_SUT_HI = 3;
	localparam int F4_SUT_LO = 2;
	localparam int F4_WATCHDOG_CONFIG_LOCK = 1;
	localparam int F4_TPEN = 0;
	localparam logic [7:0] NVM_INTERRUPT_CONTROL_MASK = 8'h0f;

	// ----------------------------------------
	// Commands (CMD register low bits)
	// ----------------------------------------
	localparam logic [6:0] CMD_NOP = 7'h00;
	localparam logic [6:0] CMD_EE_LOAD = 7'h33;
	localparam logic [6:0] CMD_EE_FLUSH = 7'h36;
	localparam logic [6:0] CMD_EE_WRITE = 7'h35;
	localparam logic [6:0] CMD_FL_LOAD = 7'h23;
	localparam logic [6:0] CMD_FL_FLUSH = 7'h26;
	localparam logic [6:0] CMD_APP_WRITE = 7'h24;
	localparam logic [6:0] CMD_BOOT_WRITE = 7'h2c;
	localparam logic [6:0] CMD_APP_ERASE = 7'h22;
	localparam logic [6:0] CMD_LOCK_WRITE = 7'h08;
	localparam logic [7:0] CCP_KEY = 8'hd8;
	localparam logic [2:0] CCP_WINDOW = 3'h4;

	// ----------------------------------------
	// Start-up delay in 1 kHz oscillator cycles
	// ----------------------------------------
	localparam logic [1:0] SUT_64 = 2'h0;
	localparam logic [1:0] SUT_4 = 2'h1;
	localparam logic [1:0] SUT_0 = 2'h3;
	localparam logic [6:0] SUT_CNT_64 = 7'h40;
	localparam logic [6:0] SUT_CNT_4 = 7'h04;
	localparam logic [6:0] SUT_CNT_0 = 7'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} nvmsf_bus_t;

	typedef struct packed {
		logic [7:0] user_ident;
		logic [3:0] window_period;
		logic [3:0] timeout_period;
		logic boot_vector_app;
		logic [1:0] brownout_sleep_mode;
		logic ext_reset_pin_disable;
		logic watchdog_config_lock;
		logic watchdog_auto_enable;
		logic test_port_enable;
	} nvmsf_cfg_t;

	typedef enum logic [2:0] {
		ST_LOAD = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} nvmsf_state_t;

endpackage

// File: sim/test_nvmsf_top.sv
`timescale 1ns/1ns
module test_nvmsf_top;
	localparam int BUSY_N = 4;
	logic i_clk;
	logic i_rst_n;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic i_ccp_key_wr;
	logic i_ulp_tick;
	logic i_ext_reset_n;
	logic [7:0] o_rdata;
	logic [1:0] o_selfprog_irq_level;
	logic [1:0] o_eeprom_irq_level;
	logic o_flash_section_busy;
	logic o_ext_reset;
	logic o_internal_reset;
	nvmsf_pkg::nvmsf_cfg_t o_cfg;
	int err_total;
	int num_checks;

	nvmsf_top #(.BUSY_CYCLES(BUSY_N)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_ccp_key_wr(i_ccp_key_wr), .i_ulp_tick(i_ulp_tick),
		.i_ext_reset_n(i_ext_reset_n), .o_rdata(o_rdata), .o_selfprog_irq_level(o_selfprog_irq_level),
		.o_eeprom_irq_level(o_eeprom_irq_level), .o_flash_section_busy(o_flash_section_busy),
		.o_ext_reset(o_ext_reset), .o_internal_reset(o_internal_reset), .o_cfg(o_cfg));

	// Free-running 125 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge i_clk);
		i_addr <= addr;
		i_wdata <= data;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic bus_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge i_clk);
		i_addr <= addr;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		data = o_rdata;
	endtask

	task automatic read_check(input string name, input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		bus_read(addr, d);
		check_val(name, exp, d);
	endtask

	// Command then execute, optionally behind the protection key
	task automatic exec_cmd(input logic [6:0] cmd, input logic keyed);
		bus_write(nvmsf_pkg::ADDR_CMD, {1'b0, cmd});
		@(posedge i_clk);
		i_ccp_key_wr <= keyed;
		@(posedge i_clk);
		i_ccp_key_wr <= 1'b0;
		i_addr <= nvmsf_pkg::ADDR_EXEC;
		i_wdata <= 8'h01;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	task automatic wait_idle();
		repeat (BUSY_N + 4) @(posedge i_clk);
	endtask

	task automatic load_buf(input logic [6:0] cmd);
		bus_write(nvmsf_pkg::ADDR_CMD, {1'b0, cmd});
		bus_write(nvmsf_pkg::ADDR_DATA, 8'ha5);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		read_check("fuse0", nvmsf_pkg::ADDR_FUSE0, 8'hff);
		read_check("fuse1", nvmsf_pkg::ADDR_FUSE1, 8'hff);
		read_check("fuse2", nvmsf_pkg::ADDR_FUSE2, 8'hff);
		read_check("fuse4", nvmsf_pkg::ADDR_FUSE4, 8'hfe);
		read_check("lock", nvmsf_pkg::ADDR_LOCK, 8'hff);
		read_check("status", nvmsf_pkg::ADDR_STATUS, 8'h00);
		read_check("unmapped", 8'h20, 8'h00);
		check_val("user ident", 8'hff, o_cfg.user_ident);
		check_val("window period", 8'h0f, {4'h0, o_cfg.window_period});
		check_val("timeout period", 8'h0f, {4'h0, o_cfg.timeout_period});
		check_val("boot vector", 8'h01, {7'h00, o_cfg.boot_vector_app});
		check_val("brownout mode", 8'h03, {6'h00, o_cfg.brownout_sleep_mode});
		check_val("pin disable", 8'h00, {7'h00, o_cfg.ext_reset_pin_disable});
		check_val("test port", 8'h01, {7'h00, o_cfg.test_port_enable});
		check_val("wd lock", 8'h00, {7'h00, o_cfg.watchdog_config_lock});
		check_val("wd auto en", 8'h00, {7'h00, o_cfg.watchdog_auto_enable});
	endtask

	// Mid-run reset: fuses back to reset values, internal reset held then released
	task automatic t_rereset();
		bus_write(nvmsf_pkg::ADDR_FUSE4, 8'he2);
		read_check("fuse4 wr", nvmsf_pkg::ADDR_FUSE4, 8'he2);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		#1;
		check_val("rereset hold", 8'h01, {7'h00, o_internal_reset});
		repeat (4) @(posedge i_clk);
		#1;
		check_val("rereset done", 8'h00, {7'h00, o_internal_reset});
		read_check("fuse4 again", nvmsf_pkg::ADDR_FUSE4, 8'hfe);
		check_val("wd lock again", 8'h00, {7'h00, o_cfg.watchdog_config_lock});
	endtask

	task automatic t_regs();
		bus_write(nvmsf_pkg::ADDR_FUSE0, 8'h5a);
		read_check("fuse0 rw", nvmsf_pkg::ADDR_FUSE0, 8'h5a);
		bus_write(nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL, 8'hff);
		read_check("nvm_interrupt_control", nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL, 8'h0f);
		bus_write(nvmsf_pkg::ADDR_LOCK, 8'h00);
		read_check("lock ro", nvmsf_pkg::ADDR_LOCK, 8'hff);
		bus_write(nvmsf_pkg::ADDR_STATUS, 8'hff);
		bus_write(nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL, 8'h00);
		read_check("status ro", nvmsf_pkg::ADDR_STATUS, 8'h00);
		bus_write(8'h20, 8'h77);
		read_check("unmapped wr", 8'h20, 8'h00);
	endtask

	task automatic t_ext_reset();
		@(posedge i_clk);
		i_ext_reset_n <= 1'b0;
		@(posedge i_clk);
		#1;
		check_val("ext reset low", 8'h01, {7'h00, o_ext_reset});
		i_ext_reset_n <= 1'b1;
		#1;
		check_val("ext reset high", 8'h00, {7'h00, o_ext_reset});
	endtask

	task automatic t_irq();
		bus_write(nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL, 8'h09);
		#1;
		check_val("spm level", 8'h02, {6'h00, o_selfprog_irq_level});
		check_val("ee level", 8'h01, {6'h00, o_eeprom_irq_level});
		exec_cmd(nvmsf_pkg::CMD_EE_WRITE, 1'b1);
		check_val("spm busy", 8'h00, {6'h00, o_selfprog_irq_level});
		check_val("ee busy", 8'h00, {6'h00, o_eeprom_irq_level});
		read_check("busy flag", nvmsf_pkg::ADDR_STATUS, 8'h80);
		wait_idle();
		read_check("busy done", nvmsf_pkg::ADDR_STATUS, 8'h00);
		check_val("spm back", 8'h02, {6'h00, o_selfprog_irq_level});
		check_val("ee back", 8'h01, {6'h00, o_eeprom_irq_level});
		bus_write(nvmsf_pkg::ADDR_NVM_INTERRUPT_CONTROL, 8'h00);
		#1;
		check_val("ee off", 8'h00, {6'h00, o_eeprom_irq_level});
	endtask

	task automatic t_refused();
		exec_cmd(nvmsf_pkg::CMD_EE_WRITE, 1'b0);
		read_check("no key", nvmsf_pkg::ADDR_STATUS, 8'h00);
	endtask

	task automatic t_buffers();
		logic [7:0] d;
		logic [6:0] clr [2];
		load_buf(nvmsf_pkg::CMD_EE_LOAD);
		read_check("ee load", nvmsf_pkg::ADDR_STATUS, 8'h02);
		exec_cmd(nvmsf_pkg::CMD_EE_FLUSH, 1'b1);
		wait_idle();
		read_check("ee flush", nvmsf_pkg::ADDR_STATUS, 8'h00);
		bus_write(nvmsf_pkg::ADDR_MAPLOAD, 8'h3c);
		read_check("ee mapped", nvmsf_pkg::ADDR_STATUS, 8'h02);
		exec_cmd(nvmsf_pkg::CMD_EE_WRITE, 1'b1);
		wait_idle();
		read_check("ee write", nvmsf_pkg::ADDR_STATUS, 8'h00);
		load_buf(nvmsf_pkg::CMD_FL_LOAD);
		read_check("fl load", nvmsf_pkg::ADDR_STATUS, 8'h01);
		exec_cmd(nvmsf_pkg::CMD_APP_WRITE, 1'b1);
		check_val("flash_section_busy_flag pin", 8'h01, {7'h00, o_flash_section_busy});
		bus_read(nvmsf_pkg::ADDR_STATUS, d);
		check_val("flash_section_busy_flag bits", 8'hc0, d & 8'hc0);
		wait_idle();
		read_check("app write", nvmsf_pkg::ADDR_STATUS, 8'h00);
		clr[0] = nvmsf_pkg::CMD_BOOT_WRITE;
		clr[1] = nvmsf_pkg::CMD_FL_FLUSH;
		for (int k = 0; k < 2; k++) begin
			load_buf(nvmsf_pkg::CMD_FL_LOAD);
			read_check("fl reload", nvmsf_pkg::ADDR_STATUS, 8'h01);
			exec_cmd(clr[k], 1'b1);
			wait_idle();
			read_check("fl clear", nvmsf_pkg::ADDR_STATUS, 8'h00);
		end
		exec_cmd(nvmsf_pkg::CMD_APP_ERASE, 1'b1);
		check_val("erase flash_section_busy_flag", 8'h01, {7'h00, o_flash_section_busy});
		wait_idle();
		check_val("erase done", 8'h00, {7'h00, o_flash_section_busy});
	endtask

	task automatic t_lock();
		exec_cmd(nvmsf_pkg::CMD_LOCK_WRITE, 1'b1);
		i_wdata <= 8'hf3;
		wait_idle();
		read_check("lock mirror", nvmsf_pkg::ADDR_LOCK, 8'hf3);
	endtask

	// ----------------------------------------
	// Verdict and main sequence
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hung run
	initial begin
		#200000;
		err_total++;
		complete_run();
	end

	initial begin
		err_total = 0;
		num_checks = 0;
		i_rst_n = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_ccp_key_wr = 1'b0;
		i_ulp_tick = 1'b0;
		i_ext_reset_n = 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		i_ulp_tick <= 1'b1;
		for (int n = 0; n < 10 && o_internal_reset !== 1'b0; n++) @(posedge i_clk);
		#1;
		check_val("internal reset", 8'h00, {7'h00, o_internal_reset});
		t_reset_values();
		t_regs();
		t_ext_reset();
		t_irq();
		t_refused();
		t_buffers();
		t_lock();
		t_rereset();
		complete_run();
	end
endmodule
